// ### rtl/acd_pkg.sv
// Purpose: Shared constants and types of the amplifier control bank.
// Assumes: A 200 MHz system clock and a 1 us diagnostic timebase.
// Notes:   Register codes sit in the top three bits of each byte.
package acd_pkg;
    // ----------------------------------------------------------------
    // Control byte layout
    // ----------------------------------------------------------------
    localparam int CODE_HI = 7;      // Register code, top bit.
    localparam int CODE_LO = 5;      // Register code, bottom bit.
    localparam int PAY_HI = 4;       // Payload, top bit.
    localparam int NUM_REGS = 5;     // Registers in the bank.
    localparam logic [2:0] REG_MODE = 3'h0;
    localparam logic [2:0] REG_DIAG = 3'h1;
    localparam logic [2:0] REG_IGN = 3'h2;
    localparam logic [2:0] REG_VOL_A = 3'h3;
    localparam logic [2:0] REG_VOL_B = 3'h4;
    localparam logic [4:0] PAY_RESET = 5'h00;
    // ----------------------------------------------------------------
    // Field positions inside the five-bit payload
    // ----------------------------------------------------------------
    localparam int MODE_POWER_ON = 4;   // Amplifier enable.
    localparam int MODE_IN_B = 3;       // Second input select.
    localparam int MODE_IN_A = 2;       // First input select.
    localparam int DIAG_ENABLE = 4;     // diag_enable.
    localparam int DIAG_REPEAT = 3;     // diag_repeat_mode.
    localparam int DIAG_CLEAR = 2;      // fault_clear.
    localparam int DIAG_ILIM = 1;       // current_limit_sel.
    localparam int IGN_OUT_SHORT = 0;   // Outputs shorted together.
    localparam int IGN_OPEN = 1;        // Open output.
    localparam int IGN_SUPPLY = 2;      // ignore_supply_short.
    localparam int IGN_OVERCUR = 3;     // ignore_overcurrent.
    localparam int IGN_THERMAL = 4;     // ignore_thermal.
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 200;             // System clock rate.
    localparam int TICK_US = 1;               // Timebase period in us.
    localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
    localparam logic [7:0] TICK_LAST = 8'(TICK_CYCLES - 1);
    localparam int STEP_US = 100;             // Length of one test.
    localparam logic [6:0] STEP_LAST = 7'(STEP_US / TICK_US - 1);
    localparam int PERIOD_MS = 60;            // Repeat period.
    localparam int PERIOD_US_DEF = PERIOD_MS * 1000;
    localparam logic [1:0] PH_NONE = 2'h0;    // Test phase codes.
    localparam logic [1:0] PH_SUPPLY = 2'h1;
    localparam logic [1:0] PH_SHORT = 2'h2;
    localparam logic [1:0] PH_OPEN = 2'h3;
    // Sequencer states.
    typedef enum logic [2:0] {
        SEQ_IDLE, SEQ_SUPPLY, SEQ_SHORT, SEQ_OPEN, SEQ_WAIT
    } acd_seq_t;
endpackage

// ### rtl/acd_sync.sv
// Purpose: Two-flop synchroniser bank for the analog sense inputs.
// Assumes: Inputs are slow levels from comparators.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
module acd_sync #(
    parameter int W = 5
) (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // Levels.
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_r; // First stage, read only by the second.

    // ----------------------------------------------------------------
    // Two stages
    // ----------------------------------------------------------------
    // Both stages clear on reset so no stale fault leaks out.
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            meta_r <= '0;
            sync_o <= '0;
        end else begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end
endmodule // acd_sync
`default_nettype wire

// ### rtl/acd_timebase.sv
// Purpose: Divider giving a one-cycle enable once per microsecond.
// Assumes: The clock rate of the package.
// Notes:   All diagnostic timing counts these ticks.
`timescale 1ns/1ps
`default_nettype none
module acd_timebase
    import acd_pkg::*;
(
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // Enable pulse.
    output logic tick_o
);
    logic [7:0] div_r; // Cycle counter within one tick.

    // ----------------------------------------------------------------
    // Divider
    // ----------------------------------------------------------------
    // The pulse is registered so it lasts exactly one cycle.
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            div_r <= 8'h00;
            tick_o <= 1'b0;
        end else if (div_r == TICK_LAST) begin
            div_r <= 8'h00;
            tick_o <= 1'b1;
        end else begin
            div_r <= div_r + 8'h01;
            tick_o <= 1'b0;
        end
    end
endmodule // acd_timebase
`default_nettype wire

// ### rtl/acd_regs.sv
// Purpose: Write-only control bank and output fault diagnostic sequencer.
// Assumes: A bus front end on mclk_i delivers each data byte as a strobe.
// Notes:   Sense inputs come from analog comparators and are resynced.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1: Byte top three bits select register
// R2: Mode bits: power, second, first input
// R3: Diag bits: enable, repeat, clear, limit
// R4: Power-up runs full test sequence always
// R5: Shutdown during power-up, writes held
// R6: Fault clear aborts power-up sequence
// R7: Run starts on enable rising edge
// R8: One-shot runs once; rewrite to rerun
// R9: Repeat every 60 ms until stopped
// R10: Repeat bit selects continuous mode
// R11: Enable low skips tests, protection stays
// R12: Fault keeps outputs off, indicator low
// R13: Clear edge restores outputs and indicator
// R14: Limit bit picks fixed or supply limit
// R15: Ignore bits mask indicator per test
// R16: Masked faults still disable outputs
// R17: Started sequence runs every test; a fault or clear edge ends a started run early
// R18: Registers 3, 4 hold volume codes
// R19: Volume code monotonic, zero lowest gain
// R20: Input bits mute, route or mix
// R21: Write-only; reads never acknowledged
// R22: Indicator latched until clear edge
module acd_regs
    import acd_pkg::*;
#(
    parameter int PERIOD_US = PERIOD_US_DEF // Repeat period in us.
) (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // Byte port from the serial front end.
    input wire logic wr_stb_i,
    input wire logic [7:0] wr_byte_i,
    input wire logic rd_req_i,
    output logic ack_o,
    // Analog sense comparators.
    input wire logic sense_supply_short_i,
    input wire logic sense_out_short_i,
    input wire logic sense_open_i,
    input wire logic sense_overcurrent_i,
    input wire logic sense_thermal_i,
    // Amplifier controls.
    output logic amp_enable_o,
    output logic [1:0] input_sel_o,
    output logic mute_o,
    output logic [4:0] gain_code_a_o,
    output logic [4:0] gain_code_b_o,
    output logic current_limit_sel_o,
    output logic [1:0] test_phase_o,
    output logic diag_busy_o,
    // Open-drain fault pin.
    output logic fault_n_o,
    output logic fault_oe_o
);
    import acd_pkg::*;

    // ----------------------------------------------------------------
    // Helpers and declarations
    // ----------------------------------------------------------------
    // True when a code names one of the five registers.
    function automatic logic code_valid(input logic [2:0] c);
        code_valid = (c <= REG_VOL_B);
    endfunction

    localparam logic [16:0] WAIT_LAST =
        17'(PERIOD_US / TICK_US - 3 * (STEP_US / TICK_US) - 1);

    logic tick;                        // One-microsecond enable.
    logic [4:0] sense;                 // Synchronised sense levels.
    logic [4:0] shadow_r [NUM_REGS];   // Bytes as written.
    logic [4:0] live_r [NUM_REGS];     // Bytes in force.
    logic por_r;                       // Power-up check running.
    logic en_prev_r;                   // Enable bit one cycle ago.
    logic clr_prev_r;                  // Clear bit one cycle ago.
    acd_seq_t state_r;                 // Sequencer state.
    logic [6:0] step_r;                // Ticks within one test.
    logic [16:0] wait_r;               // Ticks between sequences.
    logic fault_lat_r;                 // Outputs held off by a fault.
    logic fault_ind_r;                 // Indicator asserted.
    logic [2:0] wr_code;               // Code of the incoming byte.
    logic wr_ok;                       // Byte targets a real register.
    logic abort_por;                   // Clear written during power-up.
    logic start_req;                   // Enable rising edge.
    logic clr_rise;                    // Clear bit rising edge.
    logic step_end;                    // Last tick of a test.
    logic [4:0] tfault;                // Faults detected this cycle.
    logic new_fault;                   // Any fault detected.
    logic ind_set;                     // Unmasked fault detected.
    logic repeat_on;                   // Continuous mode selected.

    acd_timebase u_tb (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .tick_o(tick)
    );

    acd_sync #(.W(5)) u_sync (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .async_i({sense_thermal_i, sense_overcurrent_i,
                  sense_supply_short_i, sense_open_i,
                  sense_out_short_i}),
        .sync_o(sense)
    );

    // ----------------------------------------------------------------
    // Write decode
    // ----------------------------------------------------------------
    assign wr_code = wr_byte_i[CODE_HI:CODE_LO]; // R1
    assign wr_ok = wr_stb_i && code_valid(wr_code); // R1
    // A clear written while the power-up check runs ends it at once.
    assign abort_por = por_r && wr_ok && (wr_code == REG_DIAG) &&
                       wr_byte_i[DIAG_CLEAR]; // R6
    assign repeat_on = live_r[REG_DIAG][DIAG_REPEAT]; // R10
    assign start_req = live_r[REG_DIAG][DIAG_ENABLE] && !en_prev_r; // R7
    assign clr_rise = live_r[REG_DIAG][DIAG_CLEAR] && !clr_prev_r; // R13
    assign step_end = tick && (step_r == STEP_LAST);

    // Only writes are answered; a read request never gets an ack.
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= wr_ok && !rd_req_i; // R21
        end
    end

    // Every accepted byte lands in the shadow copy, busy or not.
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                shadow_r[i] <= PAY_RESET;
            end
        end else if (wr_ok) begin
            shadow_r[wr_code] <= wr_byte_i[PAY_HI:0]; // R1 R18
        end
    end

    // The live copy is frozen during the power-up check so that the
    // amplifier stays in shutdown; held bytes take effect afterwards.
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                live_r[i] <= PAY_RESET;
            end
        end else if (!por_r) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                live_r[i] <= shadow_r[i]; // R5
            end
        end
    end

    // Edge memories. Frozen with the live copy, so the first cycle
    // after the check sees any enable that was written meanwhile.
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            en_prev_r <= 1'b0;
            clr_prev_r <= 1'b0;
        end else begin
            en_prev_r <= live_r[REG_DIAG][DIAG_ENABLE]; // R7
            clr_prev_r <= live_r[REG_DIAG][DIAG_CLEAR]; // R13
        end
    end

    // ----------------------------------------------------------------
    // Fault detection
    // ----------------------------------------------------------------
    // Load tests only count in their own phase; over-current and
    // thermal are watched at all times.
    always_comb begin
        tfault = 5'h00;
        tfault[IGN_OUT_SHORT] = (state_r == SEQ_SHORT) && sense[0];
        tfault[IGN_OPEN] = (state_r == SEQ_OPEN) && sense[1]; // R11
        tfault[IGN_SUPPLY] = (state_r == SEQ_SUPPLY) && sense[2];
        tfault[IGN_OVERCUR] = sense[3]; // R11
        tfault[IGN_THERMAL] = sense[4]; // R11
    end

    assign new_fault = |tfault; // R16
    assign ind_set = |(tfault & ~live_r[REG_IGN]); // R15

    // Fault latch: any fault stops the outputs, masked or not. The
    // set wins over a clear edge that lands in the same cycle.
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            fault_lat_r <= 1'b0;
        end else if (new_fault) begin
            fault_lat_r <= 1'b1; // R16
        end else if (clr_rise) begin
            fault_lat_r <= 1'b0; // R13
        end
    end

    // Indicator latch: stays asserted after the fault goes away and
    // through repeated tests; only a clear edge releases it.
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            fault_ind_r <= 1'b0;
        end else if (ind_set) begin
            fault_ind_r <= 1'b1; // R15 R12
        end else if (clr_rise) begin
            fault_ind_r <= 1'b0; // R22
        end
    end

    // ----------------------------------------------------------------
    // Diagnostic sequencer
    // ----------------------------------------------------------------
    // Reset enters the supply test with the power-up flag set, so the
    // first check runs whatever the enable bit says.
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            state_r <= SEQ_SUPPLY; // R4
            por_r <= 1'b1; // R4
            step_r <= 7'h00;
            wait_r <= 17'h00000;
        end else if (abort_por) begin
            state_r <= SEQ_IDLE; // R6
            por_r <= 1'b0;
            step_r <= 7'h00;
        end else begin
            if (tick) begin
                step_r <= step_end ? 7'h00 : step_r + 7'h01;
            end
            case (state_r)
                SEQ_IDLE: begin
                    step_r <= 7'h00;
                    // A busy sequencer drops the edge: one run only.
                    if (start_req) begin
                        state_r <= SEQ_SUPPLY; // R7 R8
                    end
                end
                // A started run visits all three tests, mask or not;
                // only a fault or a clear edge cuts it short.
                SEQ_SUPPLY: begin
                    if (!por_r && (new_fault || clr_rise)) begin
                        state_r <= SEQ_IDLE; // R9
                    end else if (step_end) begin
                        state_r <= SEQ_SHORT; // R17
                    end
                end
                SEQ_SHORT: begin
                    if (!por_r && (new_fault || clr_rise)) begin
                        state_r <= SEQ_IDLE; // R9
                    end else if (step_end) begin
                        state_r <= SEQ_OPEN; // R17
                    end
                end
                SEQ_OPEN: begin
                    if (!por_r && (new_fault || clr_rise)) begin
                        state_r <= SEQ_IDLE; // R9
                    end else if (step_end) begin
                        if (por_r) begin
                            state_r <= SEQ_IDLE; // R5
                            por_r <= 1'b0;
                        end else if (repeat_on) begin
                            state_r <= SEQ_WAIT; // R9
                            wait_r <= 17'h00000;
                        end else begin
                            state_r <= SEQ_IDLE; // R8
                        end
                    end
                end
                // Pause so that runs start one period apart.
                SEQ_WAIT: begin
                    step_r <= 7'h00;
                    if (new_fault || clr_rise || !repeat_on) begin
                        state_r <= SEQ_IDLE; // R9
                    end else if (tick && wait_r == WAIT_LAST) begin
                        state_r <= SEQ_SUPPLY; // R9
                    end else if (tick) begin
                        wait_r <= wait_r + 17'h00001;
                    end
                end
                default: begin
                    state_r <= SEQ_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    // The amplifier runs only when powered on, past the power-up
    // check, and free of any latched fault.
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            amp_enable_o <= 1'b0;
        end else begin
            amp_enable_o <= live_r[REG_MODE][MODE_POWER_ON] && !por_r &&
                            !fault_lat_r; // R2 R5 R12
        end
    end

    // Input routing, gain codes and limit mode follow the live copy.
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            input_sel_o <= 2'h0;
            mute_o <= 1'b1;
            gain_code_a_o <= PAY_RESET;
            gain_code_b_o <= PAY_RESET;
            current_limit_sel_o <= 1'b0;
        end else begin
            input_sel_o <= {live_r[REG_MODE][MODE_IN_B],
                            live_r[REG_MODE][MODE_IN_A]}; // R2 R20
            mute_o <= !live_r[REG_MODE][MODE_IN_B] &&
                      !live_r[REG_MODE][MODE_IN_A]; // R20
            // Codes go straight to a monotonic gain ladder.
            gain_code_a_o <= live_r[REG_VOL_A]; // R18 R19
            gain_code_b_o <= live_r[REG_VOL_B]; // R18 R19
            current_limit_sel_o <= live_r[REG_DIAG][DIAG_ILIM]; // R3 R14
        end
    end

    // Phase code steers the analog test hardware.
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            test_phase_o <= PH_NONE;
            diag_busy_o <= 1'b0;
        end else begin
            case (state_r)
                SEQ_SUPPLY: test_phase_o <= PH_SUPPLY;
                SEQ_SHORT: test_phase_o <= PH_SHORT;
                SEQ_OPEN: test_phase_o <= PH_OPEN;
                default: test_phase_o <= PH_NONE;
            endcase
            diag_busy_o <= (state_r != SEQ_IDLE);
        end
    end

    // Open drain: the pin is pulled low only while a fault is shown.
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            fault_n_o <= 1'b1;
            fault_oe_o <= 1'b0;
        end else begin
            fault_n_o <= !fault_ind_r; // R12 R22
            fault_oe_o <= fault_ind_r;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_no_read_ack;
        @(posedge mclk_i) disable iff (!reset_n_i)
        rd_req_i |=> !ack_o;
    endproperty
    a_no_read_ack: assert property (p_no_read_ack) // R21
        else $error("Read request was acknowledged.");

    property p_write_ack;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (wr_stb_i && !rd_req_i &&
            wr_byte_i[CODE_HI:CODE_LO] <= REG_VOL_B) |=> ack_o;
    endproperty
    a_write_ack: assert property (p_write_ack) // R1
        else $error("Valid write was not acknowledged.");

    property p_por_off;
        @(posedge mclk_i) disable iff (!reset_n_i)
        por_r [*2] |=> !amp_enable_o;
    endproperty
    a_por_off: assert property (p_por_off) // R5
        else $error("Amplifier enabled during power-up check.");

    property p_por_abort;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (por_r && wr_stb_i && wr_byte_i[CODE_HI:CODE_LO] == REG_DIAG &&
            wr_byte_i[DIAG_CLEAR]) |=> !por_r && state_r == SEQ_IDLE;
    endproperty
    a_por_abort: assert property (p_por_abort) // R6
        else $error("Clear did not abort power-up check.");

    property p_start;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (state_r == SEQ_IDLE && !por_r &&
            $rose(live_r[REG_DIAG][DIAG_ENABLE])) |=> state_r == SEQ_SUPPLY;
    endproperty
    a_start: assert property (p_start) // R7
        else $error("Enable edge did not start a run.");

    property p_oneshot;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (state_r == SEQ_OPEN && step_end && !por_r &&
            !live_r[REG_DIAG][DIAG_REPEAT] && !new_fault && !clr_rise)
            |=> state_r == SEQ_IDLE;
    endproperty
    a_oneshot: assert property (p_oneshot) // R8
        else $error("One-shot run did not stop.");

    property p_fault_hold;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (fault_ind_r && !clr_rise) |=> fault_ind_r ##1 !fault_n_o;
    endproperty
    a_fault_hold: assert property (p_fault_hold) // R22
        else $error("Indicator released without a clear edge.");

    property p_clear;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (clr_rise && !new_fault) |=> !fault_lat_r;
    endproperty
    a_clear: assert property (p_clear) // R13
        else $error("Clear edge did not release the fault.");

    property p_masked_off;
        @(posedge mclk_i) disable iff (!reset_n_i)
        sense[4] |=> fault_lat_r ##1 !amp_enable_o;
    endproperty
    a_masked_off: assert property (p_masked_off) // R16
        else $error("Thermal fault did not disable outputs.");

    property p_limit;
        @(posedge mclk_i) disable iff (!reset_n_i)
        // Written byte, live copy, output: the bit shows three edges on.
        (wr_ok && wr_code == REG_DIAG && !por_r) |=> ##2
            current_limit_sel_o == $past(wr_byte_i[DIAG_ILIM], 3);
    endproperty
    a_limit: assert property (p_limit) // R14
        else $error("Current limit select mismatch.");
endmodule // acd_regs
`default_nettype wire

// ### bench/acd_master_model.sv
// Purpose: Serial front end stand-in that hands control bytes to the bank.
// Assumes: Each byte arrives as a one-cycle strobe on the system clock.
// Notes:   Idle byte lines show the inverse of the last byte sent.
`timescale 1ns/1ps
`default_nettype none
module acd_master_model (
    // Clock.
    input wire logic mclk_i,
    // Byte port towards the bank.
    output logic wr_stb_o,
    output logic [7:0] wr_byte_o,
    output logic rd_req_o,
    input wire logic ack_i
);
    // Quiet bus at time zero.
    initial begin
        wr_stb_o = 1'b0;
        wr_byte_o = 8'h00;
        rd_req_o = 1'b0;
    end
    // One byte per call; the registered answer stands for one cycle
    // after the strobe edge, so it is taken at the next falling edge.
    task automatic send(input logic [7:0] b, input logic rd,
                        output logic ack);
        @(negedge mclk_i);
        wr_stb_o = 1'b1;
        wr_byte_o = b;
        rd_req_o = rd;
        @(negedge mclk_i);
        ack = ack_i; // Gone again after the next rising edge.
        wr_stb_o = 1'b0;
        wr_byte_o = ~b; // Stale data must not look like a valid byte.
        @(negedge mclk_i);
        rd_req_o = 1'b0;
    endtask
endmodule // acd_master_model
`default_nettype wire

// ### bench/acd_regs_tb.sv
// Purpose: Self-checking bench of the amplifier control bank.
// Assumes: The power-up check is cut short by an abort byte.
// Notes:   Inputs change on the falling clock edge only.
`timescale 1ns/1ps
`default_nettype none
module acd_regs_tb;
    import acd_pkg::*;
    logic mclk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic sup = 1'b0; // Supply short sense level.
    logic thr = 1'b0; // Thermal sense level.
    logic stb, rd, ack, amp, mute, lim, busy, fn, foe, a;
    logic [7:0] wb;
    logic [1:0] sel, ph;
    logic [4:0] ga, gb;
    int err_total = 0;
    int samples_checked = 0;
    int cyc = 0;
    initial forever #2.5 mclk_i = ~mclk_i;
    acd_master_model master_u (.mclk_i(mclk_i), .wr_stb_o(stb),
        .wr_byte_o(wb), .rd_req_o(rd), .ack_i(ack));
    acd_regs #(.PERIOD_US(400)) dut_u (.mclk_i(mclk_i),
        .reset_n_i(reset_n_i), .wr_stb_i(stb), .wr_byte_i(wb),
        .rd_req_i(rd), .ack_o(ack), .sense_supply_short_i(sup),
        .sense_out_short_i(1'b0), .sense_open_i(1'b0),
        .sense_overcurrent_i(1'b0), .sense_thermal_i(thr),
        .amp_enable_o(amp), .input_sel_o(sel), .mute_o(mute),
        .gain_code_a_o(ga), .gain_code_b_o(gb),
        .current_limit_sel_o(lim), .test_phase_o(ph),
        .diag_busy_o(busy), .fault_n_o(fn), .fault_oe_o(foe));
    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s exp %h got %h", n, e, g);
        end
    endtask
    // Sends one byte and compares the acknowledge against e.
    task automatic w(input logic [7:0] b, input logic r, input logic e);
        master_u.send(b, r, a);
        chk("ack", 8'(e), 8'(a));
    endtask
    task automatic t(input int n);
        repeat (n) @(negedge mclk_i);
    endtask
    // A hang costs a mismatch; one full run takes about 60400 cycles.
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 65000) begin
            err_total++;
            report_and_stop();
        end
    end
    initial begin
        repeat (5) @(negedge mclk_i);
        reset_n_i = 1'b1;
        t(3);
        chk("phase", 8'(PH_SUPPLY), 8'(ph));
        w(8'h1c, 1'b0, 1'b1);
        t(3);
        chk("amp", 8'h00, 8'(amp));
        w(8'h24, 1'b0, 1'b1);
        t(4);
        chk("busy", 8'h00, 8'(busy));
        chk("amp", 8'h01, 8'(amp));
        chk("sel", 8'h03, 8'(sel));
        chk("mute", 8'h00, 8'(mute));
        $display("test power-up done");
        w(8'h61, 1'b1, 1'b0);
        w(8'h7f, 1'b0, 1'b1);
        w(8'h85, 1'b0, 1'b1);
        w(8'h22, 1'b0, 1'b1);
        w(8'hbf, 1'b0, 1'b0);
        t(3);
        chk("gain_a", 8'h1f, 8'(ga));
        chk("gain_b", 8'h05, 8'(gb));
        chk("limit", 8'h01, 8'(lim));
        $display("test registers done");
        w(8'h44, 1'b0, 1'b1);
        w(8'h30, 1'b0, 1'b1);
        t(3);
        chk("phase", 8'(PH_SUPPLY), 8'(ph));
        sup = 1'b1;
        t(6);
        chk("amp", 8'h00, 8'(amp));
        chk("fault_n", 8'h01, 8'(fn));
        sup = 1'b0;
        w(8'h24, 1'b0, 1'b1);
        t(5);
        chk("amp", 8'h01, 8'(amp));
        w(8'h20, 1'b0, 1'b1);
        w(8'h40, 1'b0, 1'b1);
        sup = 1'b1;
        t(6);
        chk("fault_n", 8'h01, 8'(fn));
        sup = 1'b0;
        thr = 1'b1;
        t(6);
        chk("fault_n", 8'h00, 8'(fn));
        chk("fault_oe", 8'h01, 8'(foe));
        chk("amp", 8'h00, 8'(amp));
        thr = 1'b0;
        t(10);
        chk("fault_n", 8'h00, 8'(fn));
        w(8'h24, 1'b0, 1'b1);
        t(5);
        chk("fault_n", 8'h01, 8'(fn));
        chk("amp", 8'h01, 8'(amp));
        $display("test faults done");
        // A full one-shot run visits all three tests, then goes idle.
        w(8'h30, 1'b0, 1'b1);
        t(20300);
        chk("phase", 8'(PH_SHORT), 8'(ph));
        t(20000);
        chk("phase", 8'(PH_OPEN), 8'(ph));
        t(20000);
        chk("phase", 8'(PH_NONE), 8'(ph));
        chk("busy", 8'h00, 8'(busy));
        $display("test one-shot done");
        report_and_stop();
    end
endmodule // acd_regs_tb
`default_nettype wire
